//--- pvs_pkg.sv
`default_nettype none
package pvs_pkg;
  // pixel and arithmetic widths
  localparam int PIX_W   = 24;
  localparam int COMP_W  = 8;
  localparam int ACC_W   = 24;
  localparam int FRAC_W  = 12;
  localparam int DIM_W   = 16;
  localparam int COEF_W  = 8;
  localparam int NPHASE  = 16;
  // linestore depth, fixed at the maximum output line width
  localparam int LINE_W  = 2048;
  localparam int LW_BITS = 11;
  // coefficient weights are in 1/256 units, tap a gets 256 - c
  localparam logic [8:0] W_ONE  = 9'h100;
  localparam logic [16:0] ROUND = 17'h00080;
  // bilinear default: coefficient of phase k is k * 16
  localparam logic [7:0] COEF_STEP = 8'h10;
  // register port map
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam logic [1:0] SEL_XCOEF = 2'h0;
  localparam logic [1:0] SEL_YCOEF = 2'h1;
  localparam logic [5:0] ADDR_STATUS = 6'h20;
  localparam logic [5:0] ADDR_OLINE  = 6'h21;
  // status bit positions
  localparam int ST_LOCK = 0;
  localparam int ST_EMIT = 1;
  localparam int ST_HRUN = 2;
  typedef enum logic [1:0] {H_SYNC, H_LINE, H_RUN} pvs_h_state_type;
  typedef enum logic [1:0] {V_FILL, V_CHK, V_EMIT} pvs_v_state_type;
endpackage : pvs_pkg
`default_nettype wire

//--- pvs_scaler.sv
//Behaviour
// - input pixel taken only on an edge where valid and ready are both high
// - output pixel handed over only when output valid and ready are both high
// - input stalls while the vertical stage emits, so an output stall also holds the input back
// - input ready is high only when another input pixel can be taken
// - 24-bit 12.12 step added into a 24-bit position accumulator per axis
// - two-tap interpolator per axis, one of 16 phases from the fraction
// - both coefficient sets are programmable, bilinear after reset
// - horizontal resampling stage feeds the vertical stage in series
// - frame sizes from 16x16; output lines at most 2048 pixels wide, the linestore depth
// - while upscaling and sink never stalls, one output pixel per cycle within each output line
// - exactly one output frame for each complete input frame
// - no frame store, only line storage between the two stages
// - 24-bit pixels; up or down scaling follows the step values alone
// - pixel data and syncs are ignored while input valid is low
// - after reset, wait for a clean frame start before producing output
`default_nettype none
module pvs_scaler (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [23:0] scale_step_x,
  input  wire logic [23:0] scale_step_y,
  input  wire logic [15:0] in_ppl,
  input  wire logic [15:0] in_lpf,
  input  wire logic [15:0] out_ppl,
  input  wire logic [15:0] out_lpf,
  input  wire logic [23:0] pixin,
  input  wire logic        pixin_vsync,
  input  wire logic        pixin_hsync,
  input  wire logic        pixin_val,
  output logic             pixin_rdy,
  output logic [23:0]      pixout,
  output logic             pixout_vsync,
  output logic             pixout_hsync,
  output logic             pixout_val,
  input  wire logic        pixout_rdy,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata
);
  // two-tap blend of each 8-bit component, rounded
  function automatic logic [23:0] blend(input logic [23:0] a,
                                        input logic [23:0] b,
                                        input logic [7:0]  c);
    logic [16:0] s;
    logic [23:0] r;
    s = '0;
    r = '0;
    for (int k = 0; k < 3; k++) begin
      s = 17'(a[k*8 +: 8] * (pvs_pkg::W_ONE - 9'(c)))
        + 17'(b[k*8 +: 8] * c) + pvs_pkg::ROUND;
      r[k*8 +: 8] = s[15:8];
    end
    return r;
  endfunction : blend
  logic [7:0]  xcoef_q [pvs_pkg::NPHASE];
  logic [7:0]  ycoef_q [pvs_pkg::NPHASE];
  logic [23:0] mem0 [pvs_pkg::LINE_W];
  logic [23:0] mem1 [pvs_pkg::LINE_W];
  localparam pvs_pkg::pvs_h_state_type H_SYNC = pvs_pkg::H_SYNC;
  localparam pvs_pkg::pvs_h_state_type H_LINE = pvs_pkg::H_LINE;
  localparam pvs_pkg::pvs_h_state_type H_RUN  = pvs_pkg::H_RUN;
  localparam pvs_pkg::pvs_v_state_type V_FILL = pvs_pkg::V_FILL;
  localparam pvs_pkg::pvs_v_state_type V_CHK  = pvs_pkg::V_CHK;
  localparam pvs_pkg::pvs_v_state_type V_EMIT = pvs_pkg::V_EMIT;
  pvs_pkg::pvs_h_state_type hst_q, hst_d;
  pvs_pkg::pvs_v_state_type vst_q;
  logic [15:0] hin_q, hin_d, hout_q, hout_d, hline_q, hline_d;
  logic [23:0] hacc_q, hacc_d, px0_q, px1_q, h_pix;
  logic [15:0] ipx2_q, ipx2_d, wcol_q, rcol_q, vin_q, vout_q;
  logic [15:0] ipy, ipy2;
  logic [23:0] vacc_q, top_pix, bot_pix;
  logic        lock_q, in_take, h_ok, h_take, line_done, h_clamp;
  logic        v_clamp, top_bank, bot_bank, out_adv, rdy_d;
  // integer input positions of the next output sample, plus two
  assign ipx2_q = {4'h0, hacc_q[23:12]} + 16'h0002;
  assign ipx2_d = {4'h0, hacc_d[23:12]} + 16'h0002;
  assign in_take = pixin_val && pixin_rdy;
  assign line_done = hst_q == H_RUN && hin_q == in_ppl && hout_q == out_ppl;
  // past the last input pixel the right tap is reused as both taps
  assign h_clamp = hin_q == in_ppl && ipx2_q > in_ppl;
  assign h_ok = hst_q == H_RUN && hout_q < out_ppl
             && (hin_q == ipx2_q || h_clamp);
  // the horizontal stage only moves while the linestore is filling
  assign h_take = h_ok && vst_q == V_FILL;
  assign h_pix = blend(h_clamp ? px1_q : px0_q, px1_q,
                       xcoef_q[hacc_q[11:8]]);
  // horizontal stage next state
  always_comb begin
    hst_d = hst_q;
    hin_d = hin_q;
    hout_d = hout_q;
    hacc_d = hacc_q;
    hline_d = hline_q;
    case (hst_q)
      H_SYNC: begin
        if (in_take && pixin_vsync && pixin_hsync) begin
          hst_d = H_RUN;
          hin_d = 16'h0001;
          hout_d = '0;
          hacc_d = '0;
          hline_d = '0;
        end
      end
      H_LINE: begin
        if (in_take && pixin_hsync) begin
          hst_d = H_RUN;
          hin_d = 16'h0001;
          hout_d = '0;
          hacc_d = '0;
        end
      end
      H_RUN: begin
        if (in_take) hin_d = hin_q + 16'h0001;
        if (h_take) begin
          hout_d = hout_q + 16'h0001;
          hacc_d = hacc_q + scale_step_x;
        end
        if (line_done) begin
          hline_d = hline_q + 16'h0001;
          hst_d = (hline_d == in_lpf) ? H_SYNC : H_LINE;
        end
      end
      default: hst_d = H_SYNC;
    endcase
  end
  // ready looks ahead at next state so it can come from a flop
  assign rdy_d = hst_d != H_RUN
              || (hin_d < in_ppl && (hout_d == out_ppl || hin_d < ipx2_d));
  // horizontal stage registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hst_q <= H_SYNC;
      hin_q <= '0;
      hout_q <= '0;
      hacc_q <= '0;
      hline_q <= '0;
      pixin_rdy <= 1'b0;
    end else begin
      hst_q <= hst_d;
      hin_q <= hin_d;
      hout_q <= hout_d;
      hacc_q <= hacc_d;
      hline_q <= hline_d;
      pixin_rdy <= rdy_d;
    end
  end
  // two-pixel window; first pixel of a line fills both taps
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      px0_q <= '0;
      px1_q <= '0;
      lock_q <= 1'b0;
    end else if (in_take && hst_q != H_RUN) begin
      if (hst_d == H_RUN) begin
        px0_q <= pixin;
        px1_q <= pixin;
        lock_q <= 1'b1;
      end
    end else if (in_take) begin
      px0_q <= px1_q;
      px1_q <= pixin;
    end
  end
  // linestores hold the last two horizontally scaled lines
  always_ff @(posedge core_clk) begin
    if (h_take && !vin_q[0]) mem0[wcol_q[10:0]] <= h_pix;
    if (h_take && vin_q[0]) mem1[wcol_q[10:0]] <= h_pix;
  end
  assign ipy = {4'h0, vacc_q[23:12]};
  assign ipy2 = ipy + 16'h0002;
  assign v_clamp = ipy2 > vin_q;
  assign top_bank = v_clamp ? ~vin_q[0] : ipy[0];
  assign bot_bank = v_clamp ? ~vin_q[0] : ~ipy[0];
  assign top_pix = top_bank ? mem1[rcol_q[10:0]] : mem0[rcol_q[10:0]];
  assign bot_pix = bot_bank ? mem1[rcol_q[10:0]] : mem0[rcol_q[10:0]];
  // output register advances when empty or being drained
  assign out_adv = vst_q == V_EMIT && (!pixout_val || pixout_rdy);
  // vertical stage: fill a line, then emit every output line it completes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vst_q <= V_FILL;
      wcol_q <= '0;
      rcol_q <= '0;
      vin_q <= '0;
      vout_q <= '0;
      vacc_q <= '0;
    end else begin
      case (vst_q)
        V_FILL: begin
          if (h_take && wcol_q == out_ppl - 16'h0001) begin
            wcol_q <= '0;
            vin_q <= vin_q + 16'h0001;
            vst_q <= V_CHK;
          end else if (h_take) begin
            wcol_q <= wcol_q + 16'h0001;
          end
        end
        V_CHK: begin
          if (vout_q < out_lpf && (ipy2 <= vin_q || vin_q == in_lpf)) begin
            rcol_q <= '0;
            vst_q <= V_EMIT;
          end else if (vin_q == in_lpf) begin
            vin_q <= '0;
            vout_q <= '0;
            vacc_q <= '0;
            vst_q <= V_FILL;
          end else begin
            vst_q <= V_FILL;
          end
        end
        V_EMIT: begin
          if (out_adv && rcol_q == out_ppl - 16'h0001) begin
            vout_q <= vout_q + 16'h0001;
            vacc_q <= vacc_q + scale_step_y;
            vst_q <= V_CHK;
          end else if (out_adv) begin
            rcol_q <= rcol_q + 16'h0001;
          end
        end
        default: vst_q <= V_FILL;
      endcase
    end
  end
  // output pixel register, held while the sink stalls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pixout <= '0;
      pixout_vsync <= 1'b0;
      pixout_hsync <= 1'b0;
      pixout_val <= 1'b0;
    end else if (out_adv) begin
      pixout <= blend(top_pix, bot_pix, ycoef_q[vacc_q[11:8]]);
      pixout_hsync <= rcol_q == '0;
      pixout_vsync <= rcol_q == '0 && vout_q == '0;
      pixout_val <= 1'b1;
    end else if (pixout_rdy) begin
      pixout_val <= 1'b0;
    end
  end
  // coefficient tables, bilinear after reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < pvs_pkg::NPHASE; k++) begin
        xcoef_q[k] <= 8'(pvs_pkg::COEF_STEP * 8'(k));
        ycoef_q[k] <= 8'(pvs_pkg::COEF_STEP * 8'(k));
      end
    end else if (reg_wr && reg_addr[5:4] == pvs_pkg::SEL_XCOEF) begin
      xcoef_q[reg_addr[3:0]] <= reg_wdata[7:0];
    end else if (reg_wr && reg_addr[5:4] == pvs_pkg::SEL_YCOEF) begin
      ycoef_q[reg_addr[3:0]] <= reg_wdata[7:0];
    end
  end
  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr[5:4] == pvs_pkg::SEL_XCOEF) begin
      reg_rdata <= {8'h00, xcoef_q[reg_addr[3:0]]};
    end else if (reg_addr[5:4] == pvs_pkg::SEL_YCOEF) begin
      reg_rdata <= {8'h00, ycoef_q[reg_addr[3:0]]};
    end else if (reg_addr == pvs_pkg::ADDR_STATUS) begin
      reg_rdata <= '0;
      reg_rdata[pvs_pkg::ST_LOCK] <= lock_q;
      reg_rdata[pvs_pkg::ST_EMIT] <= vst_q == V_EMIT;
      reg_rdata[pvs_pkg::ST_HRUN] <= hst_q == H_RUN;
    end else if (reg_addr == pvs_pkg::ADDR_OLINE) begin
      reg_rdata <= vout_q;
    end else begin
      reg_rdata <= '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_in_hold;
    hst_q == H_RUN && !pixin_rdy |=> $stable(hin_q) && $stable(px1_q);
  endproperty
  a_in_hold: assert property (p_in_hold)
    else $error("input consumed while not ready");
  property p_out_hold;
    pixout_val && !pixout_rdy |=> pixout_val && $stable(pixout)
      && $stable(pixout_hsync) && $stable(pixout_vsync);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("output changed while stalled");
  property p_out_drop;
    pixout_val && pixout_rdy && vst_q != V_EMIT |=> !pixout_val;
  endproperty
  a_out_drop: assert property (p_out_drop)
    else $error("pixel repeated after handover");
  property p_sync_pair;
    pixout_val && pixout_vsync |-> pixout_hsync;
  endproperty
  a_sync_pair: assert property (p_sync_pair)
    else $error("frame start without line start");
  property p_no_out_unlocked;
    !lock_q |-> !pixout_val && hst_q == H_SYNC;
  endproperty
  a_no_out_unlocked: assert property (p_no_out_unlocked)
    else $error("output before first frame start");
  property p_ignore_invalid;
    !pixin_val |=> $stable(px1_q) && $stable(hin_q);
  endproperty
  a_ignore_invalid: assert property (p_ignore_invalid)
    else $error("invalid input was used");
  property p_full_rate;
    vst_q == V_EMIT && pixout_rdy |=> pixout_val;
  endproperty
  a_full_rate: assert property (p_full_rate)
    else $error("emit stalled with ready sink");
  property p_step_x;
    h_take |=> hacc_q == $past(hacc_q) + $past(scale_step_x);
  endproperty
  a_step_x: assert property (p_step_x)
    else $error("x accumulator not stepped");
  property p_frame_count;
    vout_q <= out_lpf;
  endproperty
  a_frame_count: assert property (p_frame_count)
    else $error("too many output lines in frame");
  property p_indep;
    hst_q != H_RUN && $past(rst_n) |-> pixin_rdy;
  endproperty
  a_indep: assert property (p_indep)
    else $error("input blocked between lines");
endmodule : pvs_scaler
`default_nettype wire

//--- pvs_video_partner.sv
`default_nettype none
// video source and sink facing the scaler's pixel ports
module pvs_video_partner (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic [15:0] src_ppl,
  input  wire logic [15:0] src_lpf,
  input  wire logic [7:0]  junk,
  input  wire logic [23:0] color,
  input  wire logic [7:0]  gap_pct,
  input  wire logic [7:0]  stall_pct,
  input  wire logic        pixin_rdy,
  output logic [23:0]      pixin,
  output logic             pixin_vsync,
  output logic             pixin_hsync,
  output logic             pixin_val,
  output logic             pixout_rdy,
  output logic             done
);
  timeunit 1ns;
  timeprecision 100ps;
  integer      seed = 32'h670b;
  logic [15:0] col_q;
  logic [15:0] line_q;
  logic [7:0]  junk_q;
  // source holds each offer until taken; idle lines carry noise
  always @(posedge core_clk or negedge rst_n) begin
    logic [15:0] c;
    logic [15:0] l;
    logic [7:0]  j;
    if (!rst_n) begin
      {pixin, pixin_vsync, pixin_hsync, pixin_val} <= '0;
      {col_q, line_q, pixout_rdy, done} <= '0;
      junk_q <= junk;
    end else begin
      c = col_q;
      l = line_q;
      j = junk_q;
      if (pixin_val && pixin_rdy) begin
        if (j != 8'h00) begin
          j = j - 8'h01;
        end else if (c == src_ppl - 16'h0001) begin
          c = '0;
          l = l + 16'h0001;
        end else begin
          c = c + 16'h0001;
        end
      end
      col_q <= c;
      line_q <= l;
      junk_q <= j;
      done <= (l == src_lpf);
      if (pixin_val && !pixin_rdy) begin
        pixin_val <= 1'b1;
      end else if (run && l != src_lpf &&
                   $unsigned($random(seed)) % 100 >= gap_pct) begin
        pixin_val <= 1'b1;
        // pixels ahead of the first frame start are junk, not colour
        pixin <= (j != 8'h00) ? ~color : color;
        pixin_vsync <= j == 8'h00 && c == '0 && l == '0;
        pixin_hsync <= j == 8'h00 && c == '0;
      end else begin
        pixin_val <= 1'b0;
        pixin <= 24'($random(seed));
        pixin_vsync <= 1'($random(seed));
        pixin_hsync <= 1'($random(seed));
      end
      pixout_rdy <= $unsigned($random(seed)) % 100 >= stall_pct;
    end
  end
endmodule : pvs_video_partner
`default_nettype wire

//--- test_pvs_scaler.sv
`default_nettype none
module test_pvs_scaler;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, rst_n, run, done;
  logic [23:0] step_x, step_y, pixin, pixout, color;
  logic [15:0] in_ppl, in_lpf, out_ppl, out_lpf, reg_wdata, reg_rdata;
  logic        pixin_vsync, pixin_hsync, pixin_val, pixin_rdy;
  logic        pixout_vsync, pixout_hsync, pixout_val, pixout_rdy;
  logic [5:0]  reg_addr;
  logic        reg_wr, reg_rd, held, hhs, burst;
  logic [7:0]  gap_pct, stall_pct, junk;
  logic [23:0] hpix;
  integer      seed = 32'h670b;
  int          miscompares, check_count, pos, lines, frames;
  // configurations: upscale, downscale, mixed
  int ippl[3] = '{16, 32, 20};
  int ilpf[3] = '{16, 20, 16};
  int oppl[3] = '{24, 16, 16};
  int olpf[3] = '{20, 16, 24};
  int gaps[3] = '{0, 30, 20};
  int stls[3] = '{0, 40, 20};
  int jnks[3] = '{0, 5, 3};

  pvs_scaler uut (.core_clk(core_clk), .rst_n(rst_n),
    .scale_step_x(step_x), .scale_step_y(step_y), .in_ppl(in_ppl),
    .in_lpf(in_lpf), .out_ppl(out_ppl), .out_lpf(out_lpf), .pixin(pixin),
    .pixin_vsync(pixin_vsync), .pixin_hsync(pixin_hsync),
    .pixin_val(pixin_val), .pixin_rdy(pixin_rdy), .pixout(pixout),
    .pixout_vsync(pixout_vsync), .pixout_hsync(pixout_hsync),
    .pixout_val(pixout_val), .pixout_rdy(pixout_rdy), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  pvs_video_partner far_end (.core_clk(core_clk), .rst_n(rst_n), .run(run),
    .src_ppl(in_ppl), .src_lpf(in_lpf), .junk(junk), .color(color),
    .gap_pct(gap_pct), .stall_pct(stall_pct), .pixin_rdy(pixin_rdy),
    .pixin(pixin), .pixin_vsync(pixin_vsync), .pixin_hsync(pixin_hsync),
    .pixin_val(pixin_val), .pixout_rdy(pixout_rdy), .done(done));

  // 12.12 step is input over output size scaled by 4096
  function automatic logic [23:0] calc_step(input int i, input int o);
    return 24'((i * 4096) / o);
  endfunction : calc_step

  task cmp_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_bit

  task cmp_pix(input string what, input logic [23:0] exp,
               input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_pix

  task cmp_word(input string what, input logic [31:0] exp,
                input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp_word

  task reg_write(input logic [5:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task reg_read(input logic [5:0] a, output logic [15:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : reg_read

  task reg_test();
    logic [15:0] d;
    reg_read(pvs_pkg::ADDR_STATUS, d);
    cmp_bit("locked after reset", 1'b0, d[pvs_pkg::ST_LOCK]);
    for (int k = 0; k < 16; k++) begin
      reg_read(6'(k), d);
      cmp_word("x coef", 32'(8'(k) * pvs_pkg::COEF_STEP), 32'(d));
      reg_read(6'(k + 16), d);
      cmp_word("y coef", 32'(8'(k) * pvs_pkg::COEF_STEP), 32'(d));
    end
    reg_write(6'h03, 16'h0055);
    reg_read(6'h03, d);
    cmp_word("coef written", 32'h55, 32'(d));
    reg_write(6'h03, 16'h0030);
    reg_write(6'h30, 16'hffff);
    reg_read(6'h30, d);
    cmp_word("unmapped", 32'h0, 32'(d));
    $display("test registers done");
  endtask : reg_test

  // sizes change only under reset, then one frame is pushed through
  task run_cfg(input int i);
    int n;
    logic [15:0] d;
    rst_n <= 1'b0;
    run <= 1'b0;
    in_ppl <= 16'(ippl[i]);
    in_lpf <= 16'(ilpf[i]);
    out_ppl <= 16'(oppl[i]);
    out_lpf <= 16'(olpf[i]);
    step_x <= calc_step(ippl[i], oppl[i]);
    step_y <= calc_step(ilpf[i], olpf[i]);
    gap_pct <= 8'(gaps[i]);
    stall_pct <= 8'(stls[i]);
    junk <= 8'(jnks[i]);
    color <= 24'($random(seed));
    @(posedge core_clk);
    cmp_bit("ready in reset", 1'b0, pixin_rdy);
    cmp_bit("valid in reset", 1'b0, pixout_val);
    repeat (7) @(posedge core_clk);
    rst_n <= 1'b1;
    run <= 1'b1;
    n = 0;
    while (pos < oppl[i] * olpf[i] && n < 30000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (200) @(posedge core_clk);
    cmp_word("pixels", 32'(oppl[i] * olpf[i]), 32'(pos));
    cmp_word("lines", 32'(olpf[i]), 32'(lines));
    cmp_word("frames", 32'h1, 32'(frames));
    cmp_bit("source drained", 1'b1, done);
    reg_read(pvs_pkg::ADDR_STATUS, d);
    cmp_bit("locked", 1'b1, d[pvs_pkg::ST_LOCK]);
    cmp_bit("emitting", 1'b0, d[pvs_pkg::ST_EMIT]);
    cmp_bit("line active", 1'b0, d[pvs_pkg::ST_HRUN]);
    reg_read(pvs_pkg::ADDR_OLINE, d);
    cmp_word("output line", 32'h0, 32'(d));
    $display("test config %0d done", i);
  endtask : run_cfg

  // sink side: framing, data and hold under back-pressure
  always @(posedge core_clk) begin
    if (!rst_n) begin
      {pos, lines, frames, held, burst} = '0;
    end else begin
      if (held) begin
        cmp_pix("held pixel", hpix, pixout);
        cmp_bit("held valid", 1'b1, pixout_val);
        cmp_bit("held hsync", hhs, pixout_hsync);
      end
      if (burst) begin
        cmp_bit("one per cycle", 1'b1, pixout_val);
      end
      burst = 1'b0;
      if (pixout_val && pixout_rdy) begin
        cmp_bit("frame start", pos == 0, pixout_vsync);
        cmp_bit("line start", pos % out_ppl == 0, pixout_hsync);
        cmp_pix("pixel", color, pixout);
        frames += pixout_vsync;
        lines += pixout_hsync;
        pos++;
        burst = stall_pct == 8'h00 && pos % out_ppl != 0;
      end
      held = pixout_val && !pixout_rdy;
      hpix = pixout;
      hhs = pixout_hsync;
    end
  end

  task wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // a hang outside the per-configuration 30000-cycle waits ends the run as a mismatch
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    wrap_up();
  end

  initial begin
    {rst_n, run, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {step_x, step_y, gap_pct, stall_pct, junk, color} = '0;
    {in_ppl, in_lpf, out_ppl, out_lpf} = {4{16'h0010}};
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    reg_test();
    for (int i = 0; i < 3; i++) begin
      run_cfg(i);
    end
    wrap_up();
  end
endmodule : test_pvs_scaler
`default_nettype wire
